// ---- design/serial_interface.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_interface (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire serial_pkg::axil_req_t req,
  output wire serial_pkg::axil_rsp_t rsp,
  input  wire logic                  rxd,
  input  wire logic                  sck_i,
  input  wire logic                  timer_output,
  output logic                       txd,
  output logic                       sck_o,
  output logic                       sck_oe,
  output logic                       transmit_irq,
  output logic                       receive_irq
);

  typedef struct packed {
    logic [2:0]  rxd_s;
    logic        rxd_f;
    logic [2:0]  sck_s;
    logic        sck_f;
    logic [2:0]  tmr_s;
    logic        tmr_f;
    logic [4:0]  c24;
    logic        lvl24;
    logic [8:0]  c384;
    logic        lvl384;
    logic        sck_prev;
    logic        sck_o;
    logic        sck_oe;
    logic [7:0]  serial_mode_low_reg;
    logic [7:0]  serial_mode_high_reg;
    logic [7:0]  irq_mask_high_reg;
    logic [7:0]  thb;
    logic        thb_full;
    logic        tx_busy;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [5:0]  tx_pre;
    logic        txd;
    logic        rx_act;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_idx;
    logic [5:0]  rx_pre;
    logic        rx_par;
    logic [7:0]  rbuf;
    logic        rbuf_full;
    logic        perr;
    logic        ferr;
    logic        oerr;
    logic        tx_irq;
    logic        rx_irq;
    logic        awready;
    logic        wready;
    logic [2:0]  aw_idx;
    logic        aw_bad;
    logic [7:0]  wdata;
    logic        wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [5:0] bit_last(input logic [1:0] rate);
    logic [5:0] v;
    v = 6'h00;
    if (rate == serial_pkg::RATE_X16) begin
      v = serial_pkg::X16_LAST;
    end else if (rate == serial_pkg::RATE_X64) begin
      v = serial_pkg::X64_LAST;
    end
    return v;
  endfunction

  always_comb begin
    logic        fall;
    logic        rise;
    logic        int_lvl;
    logic        sck_now;
    logic        transmit_enable_bit;
    logic        receive_enable_bit;
    logic        sync;
    logic        ioe;
    logic        parity_enable_bit;
    logic        parity_sense_bit;
    logic [1:0]  src;
    logic        len7;
    logic [1:0]  rate;
    logic [3:0]  nb;
    logic        done;
    logic [11:0] fr;
    logic [7:0]  dm;
    logic [7:0]  rev;
    logic [3:0]  len;
    logic        deliver;
    logic [7:0]  dval;
    logic [7:0]  sh;
    logic [5:0]  tgt;
    st_nxt = st_r;
    fall = 1'b0;
    rise = 1'b0;
    int_lvl = 1'b0;
    sck_now = 1'b0;
    done = 1'b0;
    fr = 12'hFFF;
    dm = 8'h00;
    rev = 8'h00;
    len = 4'h0;
    deliver = 1'b0;
    dval = 8'h00;
    sh = 8'h00;
    tgt = 6'h00;
    transmit_enable_bit = st_r.serial_mode_high_reg[serial_pkg::TX_EN_POS];
    receive_enable_bit = st_r.serial_mode_high_reg[serial_pkg::RX_EN_POS];
    ioe = st_r.serial_mode_high_reg[serial_pkg::IOE_BIT];
    src = st_r.serial_mode_high_reg[1:0];
    parity_enable_bit = st_r.serial_mode_low_reg[serial_pkg::PAR_EN_POS];
    parity_sense_bit = st_r.serial_mode_low_reg[serial_pkg::PAR_SENSE_POS];
    rate = st_r.serial_mode_low_reg[1:0];
    sync = (rate == serial_pkg::RATE_SYNC);
    len7 = (st_r.serial_mode_low_reg[3:2] == serial_pkg::LEN_7);
    nb = len7 ? 4'h7 : 4'h8;

    // Pin inputs: a change counts once stages two and three agree
    st_nxt.rxd_s = {st_r.rxd_s[1:0], rxd};
    st_nxt.sck_s = {st_r.sck_s[1:0], sck_i};
    st_nxt.tmr_s = {st_r.tmr_s[1:0], timer_output};
    if (st_r.rxd_s[1] == st_r.rxd_s[2]) begin
      st_nxt.rxd_f = st_r.rxd_s[2];
    end
    if (st_r.sck_s[1] == st_r.sck_s[2]) begin
      st_nxt.sck_f = st_r.sck_s[2];
    end
    if (st_r.tmr_s[1] == st_r.tmr_s[2]) begin
      st_nxt.tmr_f = st_r.tmr_s[2];
    end

    // Oscillator dividers, half period per toggle
    if (st_r.c24 == 5'(serial_pkg::HALF_FAST - 1)) begin
      st_nxt.c24 = 5'h00;
      st_nxt.lvl24 = ~st_r.lvl24;
    end else begin
      st_nxt.c24 = st_r.c24 + 5'h01;
    end
    if (st_r.c384 == 9'(serial_pkg::HALF_SLOW - 1)) begin
      st_nxt.c384 = 9'h000;
      st_nxt.lvl384 = ~st_r.lvl384;
    end else begin
      st_nxt.c384 = st_r.c384 + 9'h001;
    end

    unique case (src)
      serial_pkg::SRC_TIMER:  int_lvl = st_r.tmr_f;
      serial_pkg::SRC_DIV24:  int_lvl = st_r.lvl24;
      serial_pkg::SRC_DIV384: int_lvl = st_r.lvl384;
      serial_pkg::SRC_EXT:    int_lvl = 1'b1;
    endcase
    sck_now = (src == serial_pkg::SRC_EXT) ? st_r.sck_f : int_lvl;
    st_nxt.sck_o = int_lvl;
    st_nxt.sck_oe = (src != serial_pkg::SRC_EXT);
    st_nxt.sck_prev = sck_now;
    // Shared clock for both directions
    fall = st_r.sck_prev & ~sck_now;
    rise = ~st_r.sck_prev & sck_now;
    st_nxt.tx_irq = 1'b0;
    st_nxt.rx_irq = 1'b0;

    // Transmit shifter advances on falling serial clock
    if (fall && st_r.tx_busy && transmit_enable_bit) begin
      if (st_r.tx_pre == bit_last(rate)) begin
        st_nxt.tx_pre = 6'h00;
        st_nxt.tx_sh = {1'b1, st_r.tx_sh[11:1]};
        st_nxt.tx_left = st_r.tx_left - 4'h1;
        if (st_r.tx_left == 4'h1) begin
          st_nxt.tx_busy = 1'b0;
          done = 1'b1;
        end
      end else begin
        st_nxt.tx_pre = st_r.tx_pre + 6'h01;
      end
    end

    // Load next character on the edge the last one ends, no idle gap
    if (fall && transmit_enable_bit && st_r.thb_full && (!st_r.tx_busy || done)) begin
      dm = len7 ? {1'b0, st_r.thb[6:0]} : st_r.thb;
      for (int i = 0; i < 8; i++) begin
        rev[i] = st_r.thb[7 - i];
      end
      if (sync) begin
        fr[7:0] = ioe ? rev : st_r.thb;
        len = 4'h8;
      end else begin
        fr[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (i < int'(nb)) begin
            fr[i + 1] = dm[i];
          end
        end
        if (parity_enable_bit) begin
          fr[nb + 4'h1] = ^dm ^ ~parity_sense_bit;
        end
        len = nb + 4'h2 + {3'h0, parity_enable_bit}
          + ((st_r.serial_mode_low_reg[7:6] == serial_pkg::STOP_TWO) ? 4'h1 : 4'h0);
      end
      st_nxt.tx_sh = fr;
      st_nxt.tx_left = len;
      st_nxt.tx_pre = 6'h00;
      st_nxt.tx_busy = 1'b1;
      st_nxt.thb_full = 1'b0;
      st_nxt.tx_irq = ~st_r.irq_mask_high_reg[serial_pkg::MK_TX_BIT];
    end
    st_nxt.txd = (transmit_enable_bit && st_nxt.tx_busy) ? st_nxt.tx_sh[0] : 1'b1;

    // Write channel: address and data taken in either order
    if (req.awvalid && st_r.awready) begin
      st_nxt.awready = 1'b0;
      st_nxt.aw_idx = req.awaddr[4:2];
      st_nxt.aw_bad = (req.awaddr[31:5] != 27'h0000000)
        || (req.awaddr[4:2] > serial_pkg::IDX_STATUS);
    end
    if (req.wvalid && st_r.wready) begin
      st_nxt.wready = 1'b0;
      st_nxt.wdata = req.wdata[7:0];
      st_nxt.wstb = req.wstrb[0];
    end
    if (st_r.bvalid && req.bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end else if (!st_nxt.awready && !st_nxt.wready && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = st_nxt.aw_bad ? serial_pkg::RESP_SLVERR : serial_pkg::RESP_OKAY;
      // Write after transmit load so a new byte is never lost
      if (st_nxt.wstb && !st_nxt.aw_bad) begin
        unique case (st_nxt.aw_idx)
          serial_pkg::IDX_MODE_LOW: st_nxt.serial_mode_low_reg = st_nxt.wdata;
          serial_pkg::IDX_MODE_HIGH: st_nxt.serial_mode_high_reg = st_nxt.wdata;
          serial_pkg::IDX_IRQ_MASK: st_nxt.irq_mask_high_reg = st_nxt.wdata;
          serial_pkg::IDX_THB: begin
            st_nxt.thb = st_nxt.wdata;
            st_nxt.thb_full = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // Read channel; clears here so receive sets below win
    if (st_r.rvalid && req.rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (req.arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = serial_pkg::RESP_OKAY;
      st_nxt.rdata = 8'h00;
      if (req.araddr[31:5] != 27'h0000000 || req.araddr[4:2] > serial_pkg::IDX_STATUS) begin
        st_nxt.rresp = serial_pkg::RESP_SLVERR;
      end else begin
        unique case (req.araddr[4:2])
          serial_pkg::IDX_MODE_LOW:  st_nxt.rdata = st_r.serial_mode_low_reg;
          serial_pkg::IDX_MODE_HIGH: st_nxt.rdata = st_r.serial_mode_high_reg;
          serial_pkg::IDX_IRQ_MASK:  st_nxt.rdata = st_r.irq_mask_high_reg;
          serial_pkg::IDX_THB:   st_nxt.rdata = st_r.thb;
          serial_pkg::IDX_RXBUF: begin
            st_nxt.rdata = st_r.rbuf;
            st_nxt.rbuf_full = 1'b0;
          end
          serial_pkg::IDX_STATUS: begin
            st_nxt.rdata = {2'h0, st_r.tx_busy, st_r.oerr, st_r.ferr, st_r.perr,
                            st_r.rbuf_full, ~st_r.thb_full};
            // Testing the flags is the only way to see and clear them
            st_nxt.perr = 1'b0;
            st_nxt.ferr = 1'b0;
            st_nxt.oerr = 1'b0;
          end
          default: begin
          end
        endcase
      end
    end

    // Receiver samples on rising serial clock
    if (!receive_enable_bit) begin
      st_nxt.rx_act = 1'b0;
      st_nxt.rx_idx = 4'h0;
    end else if (rise && sync) begin
      // Half duplex: receive holds off while transmitting
      if (!st_r.tx_busy) begin
        sh = ioe ? {st_r.rx_sh[6:0], st_r.rxd_f} : {st_r.rxd_f, st_r.rx_sh[7:1]};
        st_nxt.rx_sh = sh;
        if (st_r.rx_idx == 4'h7) begin
          st_nxt.rx_idx = 4'h0;
          deliver = 1'b1;
          dval = sh;
        end else begin
          st_nxt.rx_idx = st_r.rx_idx + 4'h1;
        end
      end
    end else if (rise && !st_r.rx_act) begin
      // At x1 the line is taken as aligned, so no confirm delay
      if (!st_r.rxd_f) begin
        st_nxt.rx_act = 1'b1;
        st_nxt.rx_pre = 6'h00;
        st_nxt.rx_par = 1'b0;
        st_nxt.rx_idx = (rate == serial_pkg::RATE_X1) ? 4'h1 : 4'h0;
      end
    end else if (rise) begin
      tgt = bit_last(rate);
      if (st_r.rx_idx == 4'h0) begin
        tgt = (rate == serial_pkg::RATE_X64) ? serial_pkg::X64_MID : serial_pkg::X16_MID;
      end
      if (st_r.rx_pre != tgt) begin
        st_nxt.rx_pre = st_r.rx_pre + 6'h01;
      end else begin
        st_nxt.rx_pre = 6'h00;
        st_nxt.rx_idx = st_r.rx_idx + 4'h1;
        if (st_r.rx_idx == 4'h0) begin
          // Glitch shorter than half a bit is dropped
          if (st_r.rxd_f) begin
            st_nxt.rx_act = 1'b0;
          end
        end else if (st_r.rx_idx <= nb) begin
          st_nxt.rx_sh = {st_r.rxd_f, st_r.rx_sh[7:1]};
          st_nxt.rx_par = st_r.rx_par ^ st_r.rxd_f;
        end else if (parity_enable_bit && st_r.rx_idx == nb + 4'h1) begin
          if ((st_r.rx_par ^ st_r.rxd_f) != ~parity_sense_bit) begin
            st_nxt.perr = 1'b1;
          end
        end else begin
          // Only the first stop bit is checked
          if (!st_r.rxd_f) begin
            st_nxt.ferr = 1'b1;
          end
          st_nxt.rx_act = 1'b0;
          deliver = 1'b1;
          dval = len7 ? {1'b0, st_r.rx_sh[7:1]} : st_r.rx_sh;
        end
      end
    end

    if (deliver) begin
      if (st_nxt.rbuf_full) begin
        st_nxt.oerr = 1'b1;
      end
      st_nxt.rbuf = dval;
      st_nxt.rbuf_full = 1'b1;
      st_nxt.rx_irq = ~st_r.irq_mask_high_reg[serial_pkg::MK_RX_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.rxd_s <= 3'h7;
      st_r.rxd_f <= 1'b1;
      st_r.serial_mode_low_reg <= serial_pkg::MODE_LOW_RST;
      st_r.serial_mode_high_reg <= serial_pkg::MODE_HIGH_RST;
      st_r.irq_mask_high_reg <= serial_pkg::IRQ_MASK_RST;
      st_r.tx_sh <= 12'hFFF;
      st_r.txd <= 1'b1;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp.awready = st_r.awready;
  assign rsp.wready = st_r.wready;
  assign rsp.bvalid = st_r.bvalid;
  assign rsp.bresp = st_r.bresp;
  assign rsp.arready = st_r.arready;
  assign rsp.rvalid = st_r.rvalid;
  assign rsp.rdata = {24'h000000, st_r.rdata};
  assign rsp.rresp = st_r.rresp;
  assign txd = st_r.txd;
  assign sck_o = st_r.sck_o;
  assign sck_oe = st_r.sck_oe;
  assign transmit_irq = st_r.tx_irq;
  assign receive_irq = st_r.rx_irq;

endmodule
`default_nettype wire

// ---- design/serial_pkg.sv ----
// Summary of operation
// - Three modes: asynchronous start-stop, clock-synchronous, and clock-synchronous I/O interface.
// - Separate shift registers (12-bit transmit, 8-bit receive) and 8-bit holding buffers for transmit and receive.
// - One serial clock serves both ways; synchronous modes run one direction at once.
// - Async rate, length, stop count and parity come from low mode register.
// - Transmit works only while high mode register bit 2 is one.
// - Holding buffer moves to shift register once the previous character finished.
// - Each asynchronous character gets a start bit, optional parity, one or two stops; synchronous ones carry data only.
// - Data leaves the transmit pin least significant bit first, most significant first in I/O interface mode.
// - Transmit interrupt request raised when the holding buffer becomes empty.
// - Transmit bits change on serial clock fall; bit is 1, 16 or 64 clocks.
// - Transmit pin marks high when disabled or nothing is shifting.
// - Mask register bit 2 suppresses the transmit interrupt request.
// - Receive works only while high mode register bit 3 is one.
// - Low input starts reception, is confirmed half a bit later except at x1, then data, parity, stop sampled.
// - Complete character moves to receive buffer and raises receive interrupt request.
// - Mask register bit 1 suppresses the receive interrupt request.
// - With parity enabled, mismatch against odd or even sense sets an error flag.
// - A low stop bit sets the framing error flag.
// - Delivering into a still-full receive buffer sets the overrun flag.
// - Receive errors raise no interrupt; software tests the flags.
// - Serial clock external, or internal from osc/24, osc/384 or timer; internal driven out.
// - Rate field codes: 00 synchronous, 01 x1, 10 x16, 11 x64.
// - Reset loads low mode register 48 hex and high mode register 00 hex.
// - High mode register bits 0 and 1 choose internal or external clock source.
package serial_pkg;

  localparam logic [7:0] MODE_LOW_RST  = 8'h48;
  localparam logic [7:0] MODE_HIGH_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

  localparam logic [2:0] IDX_MODE_LOW  = 3'h0;
  localparam logic [2:0] IDX_MODE_HIGH = 3'h1;
  localparam logic [2:0] IDX_IRQ_MASK  = 3'h2;
  localparam logic [2:0] IDX_THB    = 3'h3;
  localparam logic [2:0] IDX_RXBUF  = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;

  localparam int TX_EN_POS     = 2;
  localparam int RX_EN_POS     = 3;
  localparam int IOE_BIT       = 5;
  localparam int PAR_EN_POS    = 4;
  localparam int PAR_SENSE_POS = 5;
  localparam int MK_TX_BIT = 2;
  localparam int MK_RX_BIT = 1;

  localparam logic [1:0] RATE_SYNC = 2'h0;
  localparam logic [1:0] RATE_X1   = 2'h1;
  localparam logic [1:0] RATE_X16  = 2'h2;
  localparam logic [1:0] RATE_X64  = 2'h3;
  localparam logic [1:0] LEN_7     = 2'h2;
  localparam logic [1:0] STOP_TWO  = 2'h3;

  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_DIV24 = 2'h1;
  localparam logic [1:0] SRC_DIV384 = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;

  localparam int DIV_FAST = 24;
  localparam int DIV_SLOW = 384;
  localparam int HALF_FAST = DIV_FAST / 2;
  localparam int HALF_SLOW = DIV_SLOW / 2;
  localparam logic [5:0] X16_LAST = 6'h0F;
  localparam logic [5:0] X64_LAST = 6'h3F;
  localparam logic [5:0] X16_MID  = 6'h07;
  localparam logic [5:0] X64_MID  = 6'h1F;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

endpackage

// ---- testbench/remote_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_end #(
  parameter int BIT = 384
) (
  input  wire logic aclk,
  input  wire logic txd,
  output logic      rxd
);
  int          rx_n = 10;
  int          cap_cnt = 0;
  logic [11:0] cap = '0;

  // Idle line sits at mark, as with a pull-up
  initial rxd = 1'b1;

  // Edges launched from aclk keep data aligned with the serial clock
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask

  // Samples mid-bit; waits no longer after the last bit, so back-to-back starts are caught
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < rx_n; i++) begin
      if (i > 0) repeat (BIT) @(posedge aclk);
      cap[i] = txd;
    end
    cap_cnt++;
  end
endmodule
`default_nettype wire

// ---- testbench/serial_interface_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_interface_asserts (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire serial_pkg::axil_req_t req,
  input wire serial_pkg::axil_rsp_t rsp,
  input wire logic                  rxd,
  input wire logic                  sck_i,
  input wire logic                  timer_output,
  input wire logic                  txd,
  input wire logic                  sck_o,
  input wire logic                  sck_oe,
  input wire logic                  transmit_irq,
  input wire logic                  receive_irq
);
  logic [7:0] mk_r;
  logic [7:0] mode_r;
  logic [7:0] age_r;
  logic       both_w;

  assign both_w = req.awvalid && rsp.awready && req.wvalid && rsp.wready && req.wstrb[0];

  // Shadows assume address and data are taken at one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mk_r <= 8'h00;
      mode_r <= 8'h00;
      age_r <= 8'h00;
    end else begin
      if (both_w && req.awaddr == 32'h8) mk_r <= req.wdata[7:0];
      if (both_w && req.awaddr == 32'h4) mode_r <= req.wdata[7:0];
      age_r <= (both_w && req.awaddr == 32'h4) ? 8'h00 : age_r + {7'h00, age_r != 8'hFF};
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quiet11;
    $stable(sck_o) [*8] ##1 $stable(sck_o) [*3];
  endsequence

  AST_WR_RESP: assert property (both_w |=> rsp.bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (req.arvalid && rsp.arready |=> rsp.rvalid && !rsp.arready)
    else $error("read response missing");
  AST_RD_HOLD: assert property (rsp.rvalid && !req.rready |=> rsp.rvalid && $stable(rsp.rdata))
    else $error("read data dropped");
  AST_RD_UPPER: assert property (rsp.rvalid |-> rsp.rdata[31:8] == 24'h0)
    else $error("read data above byte");
  AST_TX_MASK: assert property (transmit_irq |-> !mk_r[2])
    else $error("masked transmit irq");
  AST_RX_MASK: assert property (receive_irq |-> !mk_r[1])
    else $error("masked receive irq");
  AST_TX_PULSE: assert property (transmit_irq |=> !transmit_irq)
    else $error("transmit irq not a pulse");
  AST_RX_PULSE: assert property (receive_irq |=> !receive_irq)
    else $error("receive irq not a pulse");
  AST_TX_MARK: assert property ((!mode_r[2]) [*3] |-> txd)
    else $error("txd not marking while disabled");
  AST_CLK_DRIVE: assert property (age_r > 8'h3 |-> sck_oe == (mode_r[1:0] != 2'h3))
    else $error("clock pin drive wrong");
  AST_DIV24: assert property (age_r > 8'h40 && mode_r[1:0] == 2'h1 && $changed(sck_o)
    |=> s_quiet11 ##1 $changed(sck_o))
    else $error("divide by 24 period wrong");
  AST_START_LOW: assert property ($rose(transmit_irq) |-> ##[0:3] !txd)
    else $error("no start bit after load");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [31:0] a;
    logic [7:0]  d;
    logic [1:0]  rs;
  } row_t;

  logic                  aclk;
  logic                  aresetn;
  serial_pkg::axil_req_t req;
  serial_pkg::axil_rsp_t rsp;
  logic                  rxd;
  logic                  txd;
  logic                  tx_irq;
  logic                  rx_irq;
  logic                  tmr = 1'b0;
  logic                  sck_o;
  logic                  sck_oe;
  int                    checked = 0;
  int                    miscompares = 0;
  int                    cyc = 0;
  int                    txn = 0;
  int                    rxn = 0;
  int                    k;
  logic [31:0]           v;
  logic [1:0]            rs;
  row_t                  rows [8] = '{
    '{1'b0, 32'h00, 8'h48, 2'h0},
    '{1'b0, 32'h04, 8'h00, 2'h0},
    '{1'b0, 32'h08, 8'h00, 2'h0},
    '{1'b0, 32'h14, 8'h01, 2'h0},
    '{1'b0, 32'h18, 8'h00, 2'h2},
    '{1'b1, 32'h00, 8'h3E, 2'h0},
    '{1'b1, 32'h40, 8'h11, 2'h2},
    '{1'b0, 32'h00, 8'h3E, 2'h0}
  };

  serial_interface i_serial_interface (.aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp),
    .rxd(rxd), .sck_i(1'b0), .timer_output(tmr), .txd(txd), .sck_o(sck_o), .sck_oe(sck_oe),
    .transmit_irq(tx_irq), .receive_irq(rx_irq));
  remote_end i_remote_end (.aclk(aclk), .txd(txd), .rxd(rxd));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn) begin
      txn <= txn + int'(tx_irq);
      rxn <= rxn + int'(rx_irq);
    end
    if (cyc == 80000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rs = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    v = rsp.rdata;
    rs = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  initial begin
    req = '0;
    req.wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      if (!rows[i].wr) chk("rdata", v, {24'h0, rows[i].d});
      chk("resp", {30'h0, rs}, {30'h0, rows[i].rs});
    end
    $display("test registers done");
    // x16, 8 bits, no parity, one stop; divide by 24, receive only
    wr(32'h0, 8'h0E);
    wr(32'h4, 8'h09);
    wr(32'hC, 8'hA5);
    repeat (2000) @(posedge aclk);
    chk("txd idle", {31'h0, txd}, 32'h1);
    chk("tx irqs", txn, 0);
    wr(32'h4, 8'h0D);
    wait (i_remote_end.cap_cnt == 1);
    chk("frame a", {20'h0, i_remote_end.cap}, {22'h0, 1'b1, 8'hA5, 1'b0});
    chk("tx irqs", txn, 1);
    wr(32'hC, 8'h3C);
    wait (txn == 2);
    wr(32'hC, 8'h96);
    wait (i_remote_end.cap_cnt == 2);
    chk("frame b", {20'h0, i_remote_end.cap}, {22'h0, 1'b1, 8'h3C, 1'b0});
    wait (i_remote_end.cap_cnt == 3);
    chk("frame c", {20'h0, i_remote_end.cap}, {22'h0, 1'b1, 8'h96, 1'b0});
    $display("test transmit done");
    i_remote_end.send({2'b11, 1'b1, 8'h5A, 1'b0}, 10);
    rd(32'h10);
    chk("rx data", v, 32'h5A);
    chk("rx irqs", rxn, 1);
    rd(32'h14);
    chk("status", v & 32'h1E, 32'h0);
    i_remote_end.send({2'b11, 1'b0, 8'h81, 1'b0}, 10);
    rd(32'h14);
    chk("framing", v & 32'h1C, 32'h08);
    rd(32'h14);
    chk("cleared", v & 32'h1C, 32'h0);
    i_remote_end.send({2'b11, 1'b1, 8'h11, 1'b0}, 10);
    rd(32'h14);
    chk("overrun", v & 32'h1C, 32'h10);
    rd(32'h10);
    chk("rx data", v, 32'h11);
    $display("test receive done");
    wr(32'h0, 8'h3E);
    i_remote_end.send({1'b1, 1'b1, 1'b0, 8'h07, 1'b0}, 11);
    rd(32'h14);
    chk("parity", v & 32'h1C, 32'h04);
    rd(32'h10);
    chk("rx data", v, 32'h07);
    wr(32'h8, 8'h06);
    k = rxn;
    i_remote_end.send({1'b1, 1'b1, 1'b1, 8'h07, 1'b0}, 11);
    rd(32'h14);
    chk("good parity", v & 32'h1E, 32'h02);
    chk("rx masked", rxn, k);
    i_remote_end.rx_n = 11;
    wr(32'hC, 8'hA5);
    wait (i_remote_end.cap_cnt == 4);
    chk("frame p", {20'h0, i_remote_end.cap}, {21'h0, 2'b10, 8'hA5, 1'b0});
    chk("tx masked", txn, 3);
    $display("test parity and mask done");
    // Reset lands mid-frame; registers must come back to their defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h0);
    chk("reset low mode", v, 32'h48);
    rd(32'h4);
    chk("reset high mode", v, 32'h0);
    chk("reset txd", {31'h0, txd}, 32'h1);
    tmr <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("clock out", {30'h0, sck_oe, sck_o}, 32'h3);
    wr(32'h4, 8'h03);
    repeat (4) @(posedge aclk);
    chk("clock in", {31'h0, sck_oe}, 32'h0);
    $display("test reset and clock done");
    complete_run();
  end
endmodule

bind serial_interface serial_interface_asserts i_serial_interface_asserts (
  .aclk(aclk), .aresetn(aresetn), .req(req), .rsp(rsp), .rxd(rxd), .sck_i(sck_i),
  .timer_output(timer_output), .txd(txd), .sck_o(sck_o), .sck_oe(sck_oe),
  .transmit_irq(transmit_irq), .receive_irq(receive_irq));
`default_nettype wire
